//--- pkg/mf_route_pkg.sv
// Constants, register map and source bundle for the multifunction pin router.
package mf_route_pkg;

    // ==========================================================
    // Geometry
    localparam int MF_PINS = 7;
    localparam int FIELD_W = 4;
    localparam int IRQ_W = 16;
    localparam int GP_W = 5;

    // ==========================================================
    // Register map (byte addresses on a 32-bit APB)
    localparam logic [11:0] ROUTE_ADDR = 12'h08c;
    localparam logic [11:0] PIN_STATE_ADDR = 12'h0a0;
    localparam logic [31:0] ROUTE_RESET = 32'h0000_1000;
    localparam logic [31:0] ROUTE_WMASK = 32'h0fff_ffff;
    localparam int STATE_DRIVE_LSB = 8;

    // ==========================================================
    // Field codes for general-purpose input, general-purpose output and the alternate function
    localparam logic [3:0] CODE_GP_IN = 4'h0;
    localparam logic [3:0] CODE_GP_OUT = 4'h1;
    localparam logic [3:0] CODE_ALT = 4'h2;

    // Drive and level pair returned by the decoder; drive low leaves the pin undriven.
    localparam logic [1:0] UNDRIVEN = 2'b00;

    // ==========================================================
    // Internal signals that may be routed to a terminal
    typedef struct packed {
        logic [IRQ_W-1:0] irq;
        logic [GP_W-1:0] gp_out;
        logic clkrun;
        logic serial_irq;
        logic inta;
        logic intc;
        logic dma_request;
        logic zv_status;
        logic zv_select0;
        logic card_audio_pwm;
        logic link_led;
        logic socket_led_a1;
        logic socket_led_a2;
        logic socket_led;
        logic gp_event;
        logic ring_out;
        logic out_a;
    } src_type;

endpackage : mf_route_pkg

//--- pkg/route_sel_if.sv
// Carrier between the router and its per-terminal decoder.
`timescale 1ns/1ps
interface route_sel_if import mf_route_pkg::*; ();
    logic [FIELD_W-1:0] code [MF_PINS];
    src_type src;
    logic [MF_PINS-1:0] drive;
    logic [MF_PINS-1:0] level;

    modport owner (output code, output src, input drive, input level);
    modport decoder (input code, input src, output drive, output level);
endinterface : route_sel_if

//--- hw/route_decode.sv
// Combinational decode of each routing field into drive enable and level.
`timescale 1ns/1ps
module route_decode import mf_route_pkg::*; (
    // Field codes in, terminal drive out
    route_sel_if.decoder rs
);

    // ==========================================================
    // Decode table
    // Most codes at or above 4 pick the IRQ of the same number, so that is
    // the starting value and only the exceptions are listed.
    function automatic logic [1:0] route_fn(input int unsigned p, input logic [3:0] c,
                                            input src_type s);
        logic [1:0] r;
        r = {1'b1, s.irq[c]};
        case (p)
            6: begin
                case (c)
                    4'h0: r = UNDRIVEN;
                    4'h1: r = {1'b1, s.clkrun};
                    4'h2: r = {1'b1, s.irq[2]};
                    4'h3: r = UNDRIVEN;
                    default: r = r;
                endcase
            end
            5: begin
                case (c)
                    4'h1: r = {1'b1, s.gp_out[4]};
                    4'h0, 4'h2, 4'h3, 4'h7: r = UNDRIVEN;
                    4'h6: r = {1'b1, s.zv_status};
                    4'h8: r = {1'b1, s.card_audio_pwm};
                    4'hb: r = {1'b1, s.link_led};
                    4'hc: r = {1'b1, s.socket_led_a1};
                    4'hd: r = {1'b1, s.socket_led};
                    4'he: r = {1'b1, s.gp_event};
                    default: r = r;
                endcase
            end
            4: begin
                case (c)
                    4'h1: r = {1'b1, s.gp_out[3]};
                    4'h0, 4'h2, 4'h3, 4'h7, 4'ha: r = UNDRIVEN;
                    4'h6: r = {1'b1, s.zv_status};
                    4'h8: r = {1'b1, s.card_audio_pwm};
                    4'hc: r = {1'b1, s.ring_out};
                    4'hd: r = {1'b1, s.socket_led};
                    4'he: r = {1'b1, s.gp_event};
                    default: r = r;
                endcase
            end
            3: begin
                case (c)
                    4'h0, 4'h3: r = UNDRIVEN;
                    4'h1: r = {1'b1, s.serial_irq};
                    4'h2: r = {1'b1, s.irq[2]};
                    default: r = r;
                endcase
            end
            2: begin
                case (c)
                    4'h0, 4'h3: r = UNDRIVEN;
                    4'h1: r = {1'b1, s.gp_out[2]};
                    4'h2: r = {1'b1, s.dma_request};
                    4'h6: r = {1'b1, s.zv_status};
                    4'h7: r = {1'b1, s.zv_select0};
                    4'h8: r = {1'b1, s.card_audio_pwm};
                    4'hb: r = {1'b1, s.intc};
                    4'hc: r = {1'b1, s.ring_out};
                    4'hd: r = {1'b1, s.out_a};
                    4'he: r = {1'b1, s.gp_event};
                    4'hf: r = {1'b1, s.irq[7]};
                    default: r = r;
                endcase
            end
            1: begin
                case (c)
                    4'hc: r = {1'b1, s.socket_led_a1};
                    4'hd: r = {1'b1, s.socket_led_a2};
                    4'he: r = {1'b1, s.gp_event};
                    4'hf: r = {1'b1, s.irq[15]};
                    default: r = UNDRIVEN;
                endcase
            end
            0: begin
                case (c)
                    4'h0: r = UNDRIVEN;
                    4'h1: r = {1'b1, s.gp_out[0]};
                    4'h2: r = {1'b1, s.inta};
                    4'h6: r = {1'b1, s.zv_status};
                    4'h7: r = {1'b1, s.zv_select0};
                    4'h8: r = {1'b1, s.card_audio_pwm};
                    4'hc: r = {1'b1, s.socket_led_a1};
                    4'hd: r = {1'b1, s.socket_led_a2};
                    4'he: r = {1'b1, s.gp_event};
                    default: r = r;
                endcase
            end
            default: r = UNDRIVEN;
        endcase
        return r;
    endfunction : route_fn

    // ==========================================================
    // One decoder per terminal
    for (genvar p = 0; p < MF_PINS; p++) begin : g_pin
        always_comb begin
            {rs.drive[p], rs.level[p]} = route_fn(p, rs.code[p], rs.src);
        end
    end

endmodule : route_decode

//--- hw/mf_pin_router.sv
// Multifunction terminal router with its routing register on APB.
//
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/1ps
module mf_pin_router import mf_route_pkg::*; (
    // Clock and resets
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic global_reset_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial EEPROM loader
    input wire logic eeprom_load,
    input wire logic [31:0] eeprom_data,
    // Internal sources
    input wire logic [IRQ_W-1:0] irq,
    input wire logic gp_output_0,
    input wire logic gp_output_2,
    input wire logic gp_output_3,
    input wire logic gp_output_4,
    input wire logic pci_clkrun,
    input wire logic serial_irq,
    input wire logic inta,
    input wire logic intc,
    input wire logic dma_request,
    input wire logic zv_status,
    input wire logic zv_select0,
    input wire logic card_audio_pwm,
    input wire logic link_led,
    input wire logic socket_led_a1,
    input wire logic socket_led_a2,
    input wire logic socket_led,
    input wire logic gp_event,
    input wire logic ring_out,
    input wire logic out_a,
    // Captured terminal inputs
    output logic gp_input_0,
    output logic gp_input_2,
    output logic gp_input_3,
    output logic gp_input_4,
    output logic dma_grant,
    output logic pci_lock,
    // Multifunction terminals
    input wire logic [MF_PINS-1:0] mf_pin_i,
    output logic [MF_PINS-1:0] mf_pin_o,
    output logic [MF_PINS-1:0] mf_pin_oe_n
);

    route_sel_if rs ();

    logic [31:0] route_q;
    logic [MF_PINS-1:0] pin_meta_q;
    logic [MF_PINS-1:0] pin_sync_q;
    logic access;
    logic wr_route;
    logic [31:0] byte_mask;

    // ==========================================================
    // Routing register
    // Asynchronous load of ROUTE_RESET from the global reset pin only, so a bus or sys
    // reset keeps the routing the board depends on; sys_rst still floats every terminal driver while it is held.
    assign access = psel && penable && pready;
    assign wr_route = access && pwrite && (paddr == ROUTE_ADDR);
    assign byte_mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

    always_ff @(posedge clk or negedge global_reset_n) begin
        if (!global_reset_n) begin
            route_q <= ROUTE_RESET;
        end else if (eeprom_load) begin
            route_q <= eeprom_data & ROUTE_WMASK;
        end else if (wr_route) begin
            route_q <= ((route_q & ~byte_mask) | (pwdata & byte_mask)) & ROUTE_WMASK;
        end
    end

    // ==========================================================
    // APB slave: one wait-free access cycle after setup.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (psel && !penable) begin
            pready <= 1'b1;
            pslverr <= (paddr != ROUTE_ADDR) && (paddr != PIN_STATE_ADDR);
            if (pwrite) begin
                prdata <= 32'h0000_0000;
            end else if (paddr == ROUTE_ADDR) begin
                prdata <= route_q;
            end else if (paddr == PIN_STATE_ADDR) begin
                prdata <= {17'h0_0000, ~mf_pin_oe_n, 1'b0, pin_sync_q};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // ==========================================================
    // Terminal input synchroniser
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_meta_q <= '0;
            pin_sync_q <= '0;
        end else begin
            pin_meta_q <= mf_pin_i;
            pin_sync_q <= pin_meta_q;
        end
    end

    // ==========================================================
    // Decode and source bundle
    for (genvar p = 0; p < MF_PINS; p++) begin : g_code
        assign rs.code[p] = route_q[p*FIELD_W +: FIELD_W];
    end

    assign rs.src = '{irq: irq,
                      gp_out: {gp_output_4, gp_output_3, gp_output_2, 1'b0, gp_output_0},
                      clkrun: pci_clkrun, serial_irq: serial_irq, inta: inta, intc: intc,
                      dma_request: dma_request, zv_status: zv_status,
                      zv_select0: zv_select0, card_audio_pwm: card_audio_pwm,
                      link_led: link_led, socket_led_a1: socket_led_a1,
                      socket_led_a2: socket_led_a2, socket_led: socket_led,
                      gp_event: gp_event, ring_out: ring_out, out_a: out_a};

    route_decode u_decode (
        .rs(rs)
    );

    // ==========================================================
    // Terminal drivers, registered so every pin changes on a clock edge, or at once when sys_rst rises.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mf_pin_o <= '0;
            mf_pin_oe_n <= '1;
        end else begin
            mf_pin_o <= rs.level & rs.drive;
            mf_pin_oe_n <= ~rs.drive;
        end
    end

    // ==========================================================
    // Input functions; a function not routed reads as zero.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            gp_input_0 <= 1'b0;
            gp_input_2 <= 1'b0;
            gp_input_3 <= 1'b0;
            gp_input_4 <= 1'b0;
            dma_grant <= 1'b0;
            pci_lock <= 1'b0;
        end else begin
            gp_input_0 <= (rs.code[0] == CODE_GP_IN) && pin_sync_q[0];
            gp_input_2 <= (rs.code[2] == CODE_GP_IN) && pin_sync_q[2];
            gp_input_3 <= (rs.code[4] == CODE_GP_IN) && pin_sync_q[4];
            gp_input_4 <= (rs.code[5] == CODE_GP_IN) && pin_sync_q[5];
            dma_grant <= (rs.code[5] == CODE_ALT) && pin_sync_q[5];
            pci_lock <= (rs.code[4] == CODE_ALT) && pin_sync_q[4];
        end
    end

    // ==========================================================
    // Checks
    // The pin flops are still held at the edge that releases sys_rst, so the
    // checks that expect a driven terminal start only from an edge at which reset was already low.
    a_rsvd_reads_zero: assert property (@(posedge clk) disable iff (sys_rst)
        psel && !penable && !pwrite && paddr == ROUTE_ADDR |=> prdata[31:28] == 4'h0)
        else $error("reserved routing bits read nonzero");
    a_pin6_irq_route: assert property (@(posedge clk) disable iff (sys_rst)
        !sys_rst && route_q[27:24] >= 4'h4 |=>
            !mf_pin_oe_n[6] && mf_pin_o[6] == $past(irq[route_q[27:24]]))
        else $error("terminal 6 does not carry the selected IRQ");
    a_pin5_link_led: assert property (@(posedge clk) disable iff (sys_rst)
        !sys_rst && route_q[23:20] == 4'hb |=> !mf_pin_oe_n[5] && mf_pin_o[5] == $past(link_led))
        else $error("terminal 5 does not carry link LED");
    a_pin4_rsvd_float: assert property (@(posedge clk) disable iff (sys_rst)
        route_q[19:16] == 4'ha || route_q[19:16] == 4'h7 |=> mf_pin_oe_n[4])
        else $error("terminal 4 driven on reserved code");
    a_pin3_serial_irq: assert property (@(posedge clk) disable iff (sys_rst)
        !sys_rst && route_q[15:12] == 4'h1 |=> !mf_pin_oe_n[3] && mf_pin_o[3] == $past(serial_irq))
        else $error("terminal 3 does not carry serial irq");
    a_pin2_irq7: assert property (@(posedge clk) disable iff (sys_rst)
        !sys_rst && route_q[11:8] == 4'hf |=> !mf_pin_oe_n[2] && mf_pin_o[2] == $past(irq[7]))
        else $error("terminal 2 does not carry IRQ7");
    a_pin1_gp_event: assert property (@(posedge clk) disable iff (sys_rst)
        !sys_rst && route_q[7:4] == 4'he |=> !mf_pin_oe_n[1] && mf_pin_o[1] == $past(gp_event))
        else $error("terminal 1 does not carry general event");
    a_pin0_inta: assert property (@(posedge clk) disable iff (sys_rst)
        !sys_rst && route_q[3:0] == 4'h2 |=> !mf_pin_oe_n[0] && mf_pin_o[0] == $past(inta))
        else $error("terminal 0 does not carry INTA");
    a_route_keeps_sysrst: assert property (@(posedge clk) disable iff (!global_reset_n)
        sys_rst && !eeprom_load |=> $stable(route_q))
        else $error("routing register changed under sys reset");
    a_route_reset_val: assert property (@(posedge clk)
        !global_reset_n ##1 !global_reset_n |-> route_q == ROUTE_RESET)
        else $error("routing register not at reset value");
    a_eeprom_load_val: assert property (@(posedge clk) disable iff (!global_reset_n)
        eeprom_load |=> route_q == ($past(eeprom_data) & ROUTE_WMASK))
        else $error("EEPROM value not loaded");
    a_gp_in_float: assert property (@(posedge clk) disable iff (sys_rst)
        route_q[3:0] == CODE_GP_IN ##1 route_q[3:0] == CODE_GP_IN |-> mf_pin_oe_n[0])
        else $error("terminal 0 driven while configured as input");

endmodule : mf_pin_router

//--- sim/board_pins.sv
// Board-side model of the seven multifunction terminals with pull-ups.
`timescale 1ns/1ps
module board_pins import mf_route_pkg::*; (
    // Device side of each terminal
    input wire logic [MF_PINS-1:0] pin_o,
    input wire logic [MF_PINS-1:0] pin_oe_n,
    // Board drivers, used only while the device leaves the pin alone
    input wire logic [MF_PINS-1:0] ext_level,
    input wire logic [MF_PINS-1:0] ext_en,
    // Resolved terminal levels
    output logic [MF_PINS-1:0] pin_i
);
    // ==========================================================
    // Wire resolution
    // The board backs off whenever the device drives, so contention never shows up as X here.
    always_comb begin
        for (int k = 0; k < MF_PINS; k++) begin
            if (!pin_oe_n[k]) begin
                pin_i[k] = pin_o[k];
            end else if (ext_en[k]) begin
                pin_i[k] = ext_level[k];
            end else begin
                pin_i[k] = 1'b1;
            end
        end
    end
endmodule : board_pins

//--- sim/mf_pin_router_tb_top.sv
// Self-checking bench for the multifunction pin router.
`timescale 1ns/1ps
module mf_pin_router_tb_top import mf_route_pkg::*; ;
    // ==========================================================
    // Stimulus and observation
    logic clk = 1'b0, sys_rst = 1'b1, global_reset_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, eeprom_load = 1'b0, er;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, eeprom_data = 32'h0, prdata, rd;
    logic [3:0] pstrb = 4'h0;
    logic pready, pslverr;
    logic [34:0] srcv = 35'h0;
    logic [6:0] ext_level = 7'h00, ext_en = 7'h00, pin_i, pin_o, pin_oe_n;
    logic [5:0] cap;
    int num_errors = 0, checked = 0;
    // Source index per terminal and code; -1 marks an undriven selection.
    int tbl [7][16] = '{
        '{-1, 16, 22, 3, 4, 5, 25, 26, 27, 9, 10, 11, 29, 30, 32, 15},
        '{-1, -1, -1, -1, -1, -1, -1, -1, -1, -1, -1, -1, 29, 30, 32, 15},
        '{-1, 17, 24, -1, 4, 5, 25, 26, 27, 9, 10, 23, 33, 34, 32, 7},
        '{-1, 21, 2, -1, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15},
        '{-1, 18, -1, -1, 4, 5, 25, -1, 27, 9, -1, 11, 33, 31, 32, 15},
        '{-1, 19, -1, -1, 4, 5, 25, -1, 27, 9, 10, 28, 29, 31, 32, 15},
        '{-1, 20, 2, -1, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15}};

    always #2.5 clk = ~clk;

    mf_pin_router dut (
        .clk(clk), .sys_rst(sys_rst), .global_reset_n(global_reset_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .eeprom_load(eeprom_load), .eeprom_data(eeprom_data), .irq(srcv[15:0]),
        .gp_output_0(srcv[16]), .gp_output_2(srcv[17]), .gp_output_3(srcv[18]),
        .gp_output_4(srcv[19]), .pci_clkrun(srcv[20]), .serial_irq(srcv[21]),
        .inta(srcv[22]), .intc(srcv[23]), .dma_request(srcv[24]), .zv_status(srcv[25]),
        .zv_select0(srcv[26]), .card_audio_pwm(srcv[27]), .link_led(srcv[28]),
        .socket_led_a1(srcv[29]), .socket_led_a2(srcv[30]), .socket_led(srcv[31]),
        .gp_event(srcv[32]), .ring_out(srcv[33]), .out_a(srcv[34]),
        .gp_input_0(cap[0]), .gp_input_2(cap[1]), .gp_input_3(cap[2]),
        .gp_input_4(cap[3]), .pci_lock(cap[4]), .dma_grant(cap[5]),
        .mf_pin_i(pin_i), .mf_pin_o(pin_o), .mf_pin_oe_n(pin_oe_n));

    board_pins board (.pin_o(pin_o), .pin_oe_n(pin_oe_n), .ext_level(ext_level),
        .ext_en(ext_en), .pin_i(pin_i));

    // ==========================================================
    // Shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer; eep raises the loader strobe during the access phase.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s, input logic eep,
                       output logic [31:0] data, output logic err);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
        @(posedge clk);
        penable <= 1'b1; eeprom_load <= eep;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) num_errors++;
        data = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0; eeprom_load <= 1'b0;
    endtask : apb

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : print_verdict

    // ==========================================================
    // Scenarios
    task automatic t_regs();
        apb(1'b1, ROUTE_ADDR, 32'hffff_ffff, 4'hf, 1'b0, rd, er);
        apb(1'b0, ROUTE_ADDR, 32'h0, 4'hf, 1'b0, rd, er);
        chk(rd, 32'h0fff_ffff);
        apb(1'b1, ROUTE_ADDR, 32'h0, 4'h4, 1'b0, rd, er);
        apb(1'b1, 12'h090, 32'h0, 4'hf, 1'b0, rd, er);
        chk(er, 1'b1);
        apb(1'b0, 12'h090, 32'h0, 4'hf, 1'b0, rd, er);
        chk(rd, 32'h0);
        apb(1'b1, PIN_STATE_ADDR, 32'h0, 4'hf, 1'b0, rd, er);
        chk(er, 1'b0);
        apb(1'b0, ROUTE_ADDR, 32'h0, 4'hf, 1'b0, rd, er);
        chk(rd, 32'h0f00_ffff);
        $display("register test done");
    endtask : t_regs

    // Six index-bit patterns tell every source apart on every terminal.
    task automatic t_decode();
        int idx;
        for (int c = 0; c < 16; c++) begin
            apb(1'b1, ROUTE_ADDR, {4'h0, {7{4'(c)}}}, 4'hf, 1'b0, rd, er);
            for (int j = 0; j < 6; j++) begin
                @(posedge clk);
                for (int i = 0; i < 35; i++) srcv[i] <= 1'(((i + 1) >> j) & 1);
                repeat (2) @(posedge clk);
                #1;
                for (int p = 0; p < 7; p++) begin
                    idx = tbl[p][c];
                    chk({pin_oe_n[p], pin_o[p]},
                        idx < 0 ? 2'b10 : {1'b0, 1'(((idx + 1) >> j) & 1)});
                end
            end
        end
        $display("decode test done");
    endtask : t_decode

    task automatic t_capture();
        logic [6:0] l;
        for (int k = 0; k < 2; k++) begin
            l = (k == 0) ? 7'h35 : 7'h4a;
            @(posedge clk);
            ext_en <= 7'h7f;
            ext_level <= l;
            apb(1'b1, ROUTE_ADDR, 32'h0, 4'hf, 1'b0, rd, er);
            repeat (4) @(posedge clk);
            #1;
            chk(cap, {2'b00, l[5], l[4], l[2], l[0]});
            apb(1'b0, PIN_STATE_ADDR, 32'h0, 4'hf, 1'b0, rd, er);
            chk(rd, {25'h0, l});
            apb(1'b1, ROUTE_ADDR, 32'h0022_0000, 4'hf, 1'b0, rd, er);
            repeat (4) @(posedge clk);
            #1;
            chk(cap, {l[5], l[4], 2'b00, l[2], l[0]});
        end
        @(posedge clk);
        ext_en <= 7'h00;
        $display("capture test done");
    endtask : t_capture

    task automatic t_eeprom();
        @(posedge clk);
        eeprom_data <= 32'hfedc_ba98;
        apb(1'b1, ROUTE_ADDR, 32'h1234_5678, 4'hf, 1'b1, rd, er);
        apb(1'b0, ROUTE_ADDR, 32'h0, 4'hf, 1'b0, rd, er);
        chk(rd, 32'h0edc_ba98);
        @(posedge clk);
        eeprom_data <= 32'h0000_5a5a;
        eeprom_load <= 1'b1;
        @(posedge clk);
        eeprom_load <= 1'b0;
        apb(1'b0, ROUTE_ADDR, 32'h0, 4'hf, 1'b0, rd, er);
        chk(rd, 32'h0000_5a5a);
        $display("loader test done");
    endtask : t_eeprom

    task automatic t_reset();
        apb(1'b1, ROUTE_ADDR, 32'h0abc_def1, 4'hf, 1'b0, rd, er);
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk(pin_oe_n, 7'h7f);
        @(posedge clk);
        sys_rst <= 1'b0;
        apb(1'b0, ROUTE_ADDR, 32'h0, 4'hf, 1'b0, rd, er);
        chk(rd, 32'h0abc_def1);
        @(posedge clk);
        global_reset_n <= 1'b0;
        srcv <= 35'h0_0020_0000;
        repeat (2) @(posedge clk);
        global_reset_n <= 1'b1;
        apb(1'b0, ROUTE_ADDR, 32'h0, 4'hf, 1'b0, rd, er);
        chk(rd, ROUTE_RESET);
        chk({pin_oe_n[3], pin_o[3]}, 2'b01);
        apb(1'b0, PIN_STATE_ADDR, 32'h0, 4'hf, 1'b0, rd, er);
        chk(rd, 32'h0000_087f);
        $display("reset test done");
    endtask : t_reset

    // ==========================================================
    // Sequence and watchdog
    initial begin
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        global_reset_n <= 1'b1;
        t_regs();
        t_decode();
        t_capture();
        t_eeprom();
        t_reset();
        print_verdict();
    end

    // The whole sequence needs about 450 cycles; this allows over forty times that.
    initial begin
        #100000;
        num_errors++;
        print_verdict();
    end
endmodule : mf_pin_router_tb_top
